/* rtl/eqr_recorder.sv */
// Functional notes
// RULE1: One event per transaction at most
// RULE2: Prefetch errors never produce events
// RULE3: Misc events recorded independent of transactions
// RULE4: Writable means enabled, not full, no abort
// RULE5: Unwritable queue drops non-stall events silently
// RULE6: Full-queue drops raise overflow
// RULE7: Stalled record retried when queue writable
// RULE8: Retry fault replaces held stall record; here a new stall is back-pressured until the held record clears
// RULE9: Retry terminate while unwritable is dropped
// RULE10: Pending stall record written once writable
// RULE11: Early-retry success may cancel pending record
// RULE12: Queue disable flushes committed, drops others
// RULE13: Abort visible before enable update completes
// RULE14: Translation disabled suppresses translation events
// RULE15: Any queue access abort sets abort error; here read aborts set it only while the queue is enabled
// RULE16: Writes only when enabled and writable
// RULE17: Sync abort keeps producer below aborting slot
// RULE18: Sync abort on empty queue keeps empty
// RULE19: Async abort may advance producer index
// RULE20: Consumer treats entries invalid after async abort
// RULE21: Controller terminates stalls after abort
// RULE22: Records are 32 bytes, little-endian
// RULE23: Producer advances only after clean write; in async mode the code advances it when the write request is accepted
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "eqr_regs.svh"

module eqr_recorder (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              sys_rst,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Fault reports from translation
    input  wire eqr_pkg::eqr_evt_t evt_in,
    output logic                   evt_ready,
    // Retry outcome for the held stall
    input  wire logic              retry_ok,
    // Queue memory port
    output eqr_pkg::eqr_mreq_t     mem_req,
    input  wire logic              mem_ready,
    input  wire eqr_pkg::eqr_mrsp_t mem_rsp,
    input  wire logic              rd_abort,
    // Status outputs
    output logic                   nonempty_irq,
    output logic                   stall_term_req
);
    import eqr_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_WAIT} eqr_wst_t;

    // Registers
    logic [2:0]   ctrl;
    logic         qen_ack;
    logic         abt_err;
    logic         ovf_err;
    logic [63:0]  base;
    logic [19:0]  prod;
    logic [19:0]  cons;
    logic [3:0]   log2size;
    logic         pend_v;
    logic [255:0] pend_rec;
    logic         pend_stall;
    eqr_wst_t     wst;
    logic [255:0] wrec;
    logic         busy;

    logic [2:0]   next_ctrl;
    logic         next_qen_ack;
    logic         next_abt_err;
    logic         next_ovf_err;
    logic [63:0]  next_base;
    logic [19:0]  next_prod;
    logic [19:0]  next_cons;
    logic [3:0]   next_log2size;
    logic         next_pend_v;
    logic [255:0] next_pend_rec;
    logic         next_pend_stall;
    eqr_wst_t     next_wst;
    logic [255:0] next_wrec;

    // Derived queue state
    logic         qen;
    logic         ten;
    logic         async_mode;
    logic [19:0]  idx_mask;
    logic [19:0]  wrap_bit;
    logic         full;
    logic         writable;
    logic         apb_wr;
    logic         apb_rd;
    logic         evt_real;
    logic         evt_take;
    logic         write_done;

    assign qen        = ctrl[`EQR_CTRL_QEN_BIT];
    assign ten        = ctrl[`EQR_CTRL_TEN_BIT];
    assign async_mode = ctrl[`EQR_CTRL_ASYNC_BIT];
    assign wrap_bit   = 20'h00001 << log2size;
    assign idx_mask   = wrap_bit - 20'h00001;
    // Full when index bits match but wrap bits differ
    assign full = ((prod & idx_mask) == (cons & idx_mask)) &&
                  ((prod & wrap_bit) != (cons & wrap_bit));
    assign writable = qen && !full && !abt_err; // RULE4
    assign busy     = (wst != ST_IDLE);
    assign nonempty_irq = (prod != cons);
    // Abort with a pending stall asks control to terminate stalls
    assign stall_term_req = abt_err && pend_v && pend_stall; // RULE21

    // APB: zero-wait slave, unmapped reads give zero with error
    assign apb_wr  = psel && penable && pwrite;
    // Read data is fetched in the setup cycle, ready for the access edge
    assign apb_rd  = psel && !penable && !pwrite;
    assign pready  = 1'b1;
    always_comb begin
        pslverr = 1'b0;
        unique case (paddr)
            `EQR_ADDR_CTRL, `EQR_ADDR_STATUS, `EQR_ADDR_GERR,
            `EQR_ADDR_GERR_ACK, `EQR_ADDR_BASE, `EQR_ADDR_PROD,
            `EQR_ADDR_CONS, `EQR_ADDR_LOG2SIZE: pslverr = 1'b0;
            default: pslverr = psel && penable;
        endcase
    end

    // Read data latched at the setup edge, stands through the access phase
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
        end else if (apb_rd) begin
            unique case (paddr)
                `EQR_ADDR_CTRL:     prdata <= {29'h0, ctrl};
                `EQR_ADDR_STATUS:   prdata <= {27'h0, busy, pend_v, full,
                                               writable, qen_ack};
                `EQR_ADDR_GERR:     prdata <= {30'h0, ovf_err, abt_err};
                `EQR_ADDR_BASE:     prdata <= base[31:0];
                `EQR_ADDR_PROD:     prdata <= {12'h0, prod};
                `EQR_ADDR_CONS:     prdata <= {12'h0, cons};
                `EQR_ADDR_LOG2SIZE: prdata <= {28'h0, log2size};
                default:            prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Event filtering: prefetch makes no events, disabled translation passes only misc events
    always_comb begin
        evt_real = evt_in.valid && !evt_in.prefetch && // RULE2
                   (evt_in.kind != EQR_EV_NONE) &&     // RULE1
                   (ten || evt_in.kind == EQR_EV_MISC); // RULE14 RULE3
    end
    // Back-pressure while the writer runs or a held stall is due to flush,
    // so a terminate event is never lost while the queue is writable
    assign evt_ready = !busy && !(pend_v && (evt_in.stall || writable)); // RULE12
    assign evt_take  = evt_real && evt_ready;
    assign write_done = (wst == ST_WAIT) && mem_rsp.valid;

    // Memory request: record at base + index * 32 bytes
    always_comb begin
        mem_req.valid = (wst == ST_REQ);
        mem_req.addr  = base + {39'h0, (prod & idx_mask), 5'h00}; // RULE22
        mem_req.data  = wrec; // RULE22
    end

    // Control, error, queue pointers and record path
    always_comb begin
        next_ctrl      = ctrl;
        next_qen_ack   = qen_ack;
        next_abt_err   = abt_err;
        next_ovf_err   = ovf_err;
        next_base      = base;
        next_prod      = prod;
        next_cons      = cons;
        next_log2size  = log2size;
        next_pend_v    = pend_v;
        next_pend_rec  = pend_rec;
        next_pend_stall = pend_stall;
        next_wst       = wst;
        next_wrec      = wrec;

        // Software writes
        if (apb_wr) begin
            unique case (paddr)
                `EQR_ADDR_CTRL:     next_ctrl = pwdata[2:0];
                `EQR_ADDR_GERR_ACK: begin
                    if (pwdata[`EQR_GERR_ABT_BIT]) next_abt_err = 1'b0;
                    if (pwdata[`EQR_GERR_OVF_BIT]) next_ovf_err = 1'b0;
                end
                `EQR_ADDR_BASE:     next_base = {32'h0, pwdata};
                `EQR_ADDR_PROD:     next_prod = pwdata[19:0];
                `EQR_ADDR_CONS:     next_cons = pwdata[19:0];
                `EQR_ADDR_LOG2SIZE: next_log2size = pwdata[3:0];
                default: ;
            endcase
        end

        // Enable ack follows only once the writer has drained
        if (!busy) begin
            next_qen_ack = qen; // RULE12 RULE13
        end

        // Retry outcome on held stall
        if (pend_v && pend_stall && retry_ok) begin
            next_pend_v = 1'b0; // RULE11 RULE8
        end

        // Incoming events
        if (evt_take) begin
            if (writable && !busy && !pend_v) begin
                next_wrec = evt_in.rec; // RULE16
                next_wst  = ST_REQ;
            end else if (evt_in.stall) begin
                // Hold stall; a later stall is back-pressured while one is held
                next_pend_v     = 1'b1; // RULE8 RULE10
                next_pend_rec   = evt_in.rec;
                next_pend_stall = 1'b1;
            end else if (!writable && full) begin
                next_ovf_err = 1'b1; // RULE6
            end
            // Other terminates when unwritable are dropped RULE5 RULE9
        end

        // Held stall goes out once the queue is writable again
        if (pend_v && writable && !busy && !evt_take && !retry_ok) begin
            next_wrec   = pend_rec; // RULE7 RULE10
            next_wst    = ST_REQ;
            next_pend_v = 1'b0;
        end

        // Writer state machine
        unique case (wst)
            ST_IDLE: ;
            ST_REQ: begin
                if (mem_ready) begin
                    next_wst = ST_WAIT;
                    if (async_mode) begin
                        next_prod = prod + 20'h00001; // RULE19
                    end
                end
            end
            ST_WAIT: begin
                if (mem_rsp.valid) begin
                    next_wst = ST_IDLE;
                    if (mem_rsp.abort) begin
                        next_abt_err = 1'b1; // RULE15 RULE17
                    end else if (!async_mode) begin
                        next_prod = prod + 20'h00001; // RULE23 RULE18
                    end
                end
            end
        endcase

        // Read aborts while the queue is enabled also flag the error, set wins over ack
        if (rd_abort && qen) begin
            next_abt_err = 1'b1; // RULE15
        end

        // Queue disabled: uncommitted terminate events are dropped
        if (!qen && wst == ST_IDLE && pend_v && !pend_stall) begin
            next_pend_v = 1'b0; // RULE12
        end
    end

    // State registers
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ctrl       <= `EQR_RST_CTRL;
            qen_ack    <= 1'b0;
            abt_err    <= 1'b0;
            ovf_err    <= 1'b0;
            base       <= 64'h0000_0000_0000_0000;
            prod       <= 20'h00000;
            cons       <= 20'h00000;
            log2size   <= `EQR_RST_LOG2SIZE;
            pend_v     <= 1'b0;
            pend_rec   <= '0;
            pend_stall <= 1'b0;
            wst        <= ST_IDLE;
            wrec       <= '0;
        end else begin
            ctrl       <= next_ctrl;
            qen_ack    <= next_qen_ack;
            abt_err    <= next_abt_err;
            ovf_err    <= next_ovf_err;
            base       <= next_base;
            prod       <= next_prod;
            cons       <= next_cons;
            log2size   <= next_log2size;
            pend_v     <= next_pend_v;
            pend_rec   <= next_pend_rec;
            pend_stall <= next_pend_stall;
            wst        <= next_wst;
            wrec       <= next_wrec;
        end
    end

    // Assertions
    property p_wr_only_writable;
        @(posedge clk_sys) disable iff (sys_rst)
        $rose(mem_req.valid) |-> $past(writable);
    endproperty
    a_wr_only_writable: assert property (p_wr_only_writable) // RULE16
        else $error("queue write started while not writable");

    property p_writable_def;
        @(posedge clk_sys) disable iff (sys_rst)
        abt_err |-> !writable;
    endproperty
    a_writable_def: assert property (p_writable_def) // RULE4
        else $error("writable while abort error active");

    property p_sync_abort_prod;
        @(posedge clk_sys) disable iff (sys_rst)
        (write_done && mem_rsp.abort && !async_mode && !apb_wr)
            |=> prod == $past(prod);
    endproperty
    a_sync_abort_prod: assert property (p_sync_abort_prod) // RULE17
        else $error("producer moved on synchronous abort");

    property p_ok_advance;
        @(posedge clk_sys) disable iff (sys_rst)
        (write_done && !mem_rsp.abort && !async_mode && !apb_wr)
            |=> prod == $past(prod) + 20'h00001;
    endproperty
    a_ok_advance: assert property (p_ok_advance) // RULE23
        else $error("producer not advanced after clean write");

    property p_abort_flag;
        @(posedge clk_sys) disable iff (sys_rst)
        (write_done && mem_rsp.abort) |=> abt_err;
    endproperty
    a_abort_flag: assert property (p_abort_flag) // RULE15
        else $error("abort error not raised");

    property p_prefetch_silent;
        @(posedge clk_sys) disable iff (sys_rst)
        (wst == ST_IDLE && !pend_v && evt_in.valid && evt_in.prefetch)
            |=> wst == ST_IDLE;
    endproperty
    a_prefetch_silent: assert property (p_prefetch_silent) // RULE2
        else $error("prefetch produced a record");

    property p_ovf;
        @(posedge clk_sys) disable iff (sys_rst)
        (evt_take && evt_real && full && !evt_in.stall && !apb_wr)
            |=> ovf_err;
    endproperty
    a_ovf: assert property (p_ovf) // RULE6
        else $error("overflow not raised on full drop");

    property p_ten_off;
        @(posedge clk_sys) disable iff (sys_rst)
        (wst == ST_IDLE && !pend_v && !ten && evt_in.valid &&
         evt_in.kind == EQR_EV_XLATE) |=> wst == ST_IDLE;
    endproperty
    a_ten_off: assert property (p_ten_off) // RULE14
        else $error("translation event while translation disabled");

    property p_stall_held;
        @(posedge clk_sys) disable iff (sys_rst)
        (evt_take && evt_real && evt_in.stall && !writable && !retry_ok)
            |=> pend_v;
    endproperty
    a_stall_held: assert property (p_stall_held) // RULE10
        else $error("stall record not held");

    c_write: cover property (@(posedge clk_sys) write_done);
    c_abort: cover property (@(posedge clk_sys) write_done && mem_rsp.abort);
    c_stall_flush: cover property (@(posedge clk_sys)
        pend_v && writable ##1 wst == ST_REQ);
    c_ovf: cover property (@(posedge clk_sys) $rose(ovf_err));
endmodule
`default_nettype wire

/* include/eqr_regs.svh */
`ifndef EQR_REGS_SVH
`define EQR_REGS_SVH
// Register byte addresses
`define EQR_ADDR_CTRL      12'h000
`define EQR_ADDR_STATUS    12'h004
`define EQR_ADDR_GERR      12'h008
`define EQR_ADDR_GERR_ACK  12'h00C
`define EQR_ADDR_BASE      12'h010
`define EQR_ADDR_PROD      12'h014
`define EQR_ADDR_CONS      12'h018
`define EQR_ADDR_LOG2SIZE  12'h01C
// Control fields
`define EQR_CTRL_QEN_BIT   0
`define EQR_CTRL_TEN_BIT   1
`define EQR_CTRL_ASYNC_BIT 2
// Status fields
`define EQR_ST_QEN_ACK_BIT 0
`define EQR_ST_WRITABLE    1
`define EQR_ST_FULL        2
`define EQR_ST_PEND        3
`define EQR_ST_BUSY        4
// Global error fields
`define EQR_GERR_ABT_BIT   0
`define EQR_GERR_OVF_BIT   1
// Reset values
`define EQR_RST_CTRL       3'h0
`define EQR_RST_LOG2SIZE   4'h4
// Record geometry: 32-byte records
`define EQR_REC_BYTES      32
`define EQR_REC_SHIFT      5
`endif

/* include/eqr_pkg.sv */
package eqr_pkg;
    // Event kind carried by a client fault report
    typedef enum logic [1:0] {
        EQR_EV_NONE,
        EQR_EV_CFG_ERR,
        EQR_EV_XLATE,
        EQR_EV_MISC
    } eqr_kind_t;

    // One fault report from the translation pipeline
    typedef struct packed {
        logic       valid;
        eqr_kind_t  kind;
        logic       stage2;
        logic       stall;
        logic       prefetch;
        logic [7:0] tag;
        logic [255:0] rec;
    } eqr_evt_t;

    // Memory write request toward the queue
    typedef struct packed {
        logic         valid;
        logic [63:0]  addr;
        logic [255:0] data;
    } eqr_mreq_t;

    // Memory write response
    typedef struct packed {
        logic valid;
        logic abort;
    } eqr_mrsp_t;
endpackage

/* tb/eqr_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none

module eqr_mem_model (
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               sys_rst,
    // Queue write port
    input  wire eqr_pkg::eqr_mreq_t mem_req,
    output logic                    mem_ready,
    output eqr_pkg::eqr_mrsp_t      mem_rsp,
    // Bench controls
    input  wire logic               abort_next,
    input  wire logic               slow
);
    import eqr_pkg::*;
    logic         busy;
    logic [1:0]   delay;
    int           done_cnt;
    logic [63:0]  last_addr;
    logic [255:0] last_data;

    // Accept one write, answer after a short or long delay
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            busy      <= 1'b0;
            delay     <= 2'h0;
            done_cnt  <= 0;
            mem_ready <= 1'b0;
            mem_rsp   <= '0;
        end else begin
            mem_rsp.valid <= 1'b0;
            // Idle abort line wanders so a stale sample is caught
            mem_rsp.abort <= ~mem_rsp.abort;
            if (mem_req.valid && mem_ready) begin
                last_addr <= mem_req.addr;
                last_data <= mem_req.data;
                busy      <= 1'b1;
                delay     <= slow ? 2'h3 : 2'h1;
                mem_ready <= 1'b0;
            end else if (busy) begin
                if (delay == 2'h0) begin
                    // Response only once the write is finished
                    mem_rsp.valid <= 1'b1;
                    mem_rsp.abort <= abort_next;
                    busy          <= 1'b0;
                    done_cnt      <= done_cnt + 1;
                end else begin
                    delay <= delay - 2'h1;
                end
            end else begin
                mem_ready <= slow ? ~mem_ready : 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

/* tb/event_queue_recorder_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "eqr_regs.svh"

module event_queue_recorder_test;
    import eqr_pkg::*;
    localparam logic [31:0] BASE = 32'h0000_1000;
    logic         clk_sys = 1'b0;
    logic         sys_rst = 1'b1;
    logic         psel = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite = 1'b0;
    logic [11:0]  paddr = 12'h000;
    logic [31:0]  pwdata = 32'h0;
    logic [31:0]  prdata, rd;
    logic         pready, pslverr, serr, evt_ready, nonempty_irq;
    logic         stall_term_req, mem_ready;
    logic         retry_ok = 1'b0;
    logic         rd_abort = 1'b0;
    logic         abort_next = 1'b0;
    logic         slow = 1'b0;
    eqr_evt_t     evt_in = '0;
    eqr_mreq_t    mem_req;
    eqr_mrsp_t    mem_rsp;
    logic [31:0]  seed = 32'hC7EC9624;
    logic [255:0] rec, held;
    int           fail_count = 0;
    int           checks_done = 0;
    int           wn = 0;
    int           i;

    eqr_recorder dut_u (.clk_sys, .sys_rst, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .evt_in, .evt_ready,
        .retry_ok, .mem_req, .mem_ready, .mem_rsp, .rd_abort,
        .nonempty_irq, .stall_term_req);
    eqr_mem_model mem_u (.clk_sys, .sys_rst, .mem_req, .mem_ready,
        .mem_rsp, .abort_next, .slow);

    // 40 MHz clock
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // A wait that ran out ends the run
    task automatic hang();
        fail_count++;
        $display("[FAIL] t=%0t wait ran out got=%h exp=%h", $time, 0, 1);
        give_verdict();
    endtask

    // One APB transfer; ends one idle cycle after the access edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1) hang();
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    // One register read; data taken at the access edge
    task automatic rdreg(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    // Offer one fault report with random payload until it is taken
    task automatic send(input eqr_kind_t kd, input logic st,
                        input logic pf);
        int k;
        for (k = 0; k < 8; k++) rec[k*32+:32] = xs();
        slow <= rec[0];
        evt_in <= '{valid: 1'b1, kind: kd, stage2: rec[1], stall: st,
                    prefetch: pf, tag: rec[15:8], rec: rec};
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (evt_ready !== 1'b1 && k < 50);
        if (evt_ready !== 1'b1) hang();
        evt_in.valid <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic wait_wr();
        int k;
        wn++;
        for (k = 0; k < 80 && mem_u.done_cnt != wn; k++) @(posedge clk_sys);
        if (mem_u.done_cnt != wn) hang();
        repeat (3) @(posedge clk_sys);
    endtask

    // Quiet period long enough for any write to have started and ended
    task automatic no_wr();
        repeat (20) @(posedge clk_sys);
        chk(mem_u.done_cnt, wn);
    endtask

    initial begin
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        rdreg(`EQR_ADDR_CTRL);
        chk(rd, 32'h0);
        rdreg(`EQR_ADDR_LOG2SIZE);
        chk(rd, 32'h4);
        rdreg(12'h020);
        chk({rd, 31'h0, serr}, {32'h0, 32'h1});
        // Two-entry queue, filled to the brim with random records
        apb(1'b1, `EQR_ADDR_LOG2SIZE, 32'h1);
        apb(1'b1, `EQR_ADDR_BASE, BASE);
        apb(1'b1, `EQR_ADDR_CTRL, 32'h3);
        for (i = 0; i < 2; i++) begin
            send(EQR_EV_XLATE, 1'b0, 1'b0);
            wait_wr();
            chk(mem_u.last_addr, BASE + i * 32);
            chk(mem_u.last_data, rec);
            rdreg(`EQR_ADDR_PROD);
            chk(rd, i + 1);
        end
        send(EQR_EV_XLATE, 1'b0, 1'b0);
        no_wr();
        rdreg(`EQR_ADDR_GERR);
        chk(rd[1], 1);
        rdreg(`EQR_ADDR_STATUS);
        chk(rd[2:1], 2'b10);
        // Drain; prefetch and translation-off faults stay silent
        apb(1'b1, `EQR_ADDR_CONS, 32'h2);
        apb(1'b1, `EQR_ADDR_GERR_ACK, 32'h2);
        send(EQR_EV_CFG_ERR, 1'b0, 1'b1);
        apb(1'b1, `EQR_ADDR_CTRL, 32'h1);
        send(EQR_EV_XLATE, 1'b0, 1'b0);
        no_wr();
        send(EQR_EV_MISC, 1'b0, 1'b0);
        wait_wr();
        rdreg(`EQR_ADDR_PROD);
        chk(rd, 32'h3);
        // Synchronous abort on the first write into an empty queue
        apb(1'b1, `EQR_ADDR_CTRL, 32'h3);
        apb(1'b1, `EQR_ADDR_CONS, 32'h3);
        abort_next <= 1'b1;
        send(EQR_EV_MISC, 1'b0, 1'b0);
        wait_wr();
        abort_next <= 1'b0;
        rdreg(`EQR_ADDR_PROD);
        chk({rd, 31'h0, nonempty_irq}, {32'h3, 32'h0});
        rdreg(`EQR_ADDR_GERR);
        chk(rd[0], 1);
        // Stall held behind the abort, written once acknowledged
        send(EQR_EV_XLATE, 1'b1, 1'b0);
        held = rec;
        no_wr();
        chk(stall_term_req, 1);
        rdreg(`EQR_ADDR_STATUS);
        chk(rd[3], 1);
        apb(1'b1, `EQR_ADDR_GERR_ACK, 32'h1);
        wait_wr();
        chk(mem_u.last_data, held);
        // Held stall cancelled by a successful retry
        apb(1'b1, `EQR_ADDR_CTRL, 32'h2);
        rdreg(`EQR_ADDR_STATUS);
        chk(rd[0], 0);
        send(EQR_EV_XLATE, 1'b1, 1'b0);
        retry_ok <= 1'b1;
        @(posedge clk_sys);
        retry_ok <= 1'b0;
        apb(1'b1, `EQR_ADDR_CTRL, 32'h3);
        no_wr();
        // Asynchronous abort lets the producer move on
        apb(1'b1, `EQR_ADDR_CTRL, 32'h7);
        abort_next <= 1'b1;
        send(EQR_EV_MISC, 1'b0, 1'b0);
        wait_wr();
        abort_next <= 1'b0;
        rdreg(`EQR_ADDR_PROD);
        chk(rd, 32'h5);
        // Consumer drops every entry after the asynchronous abort
        apb(1'b1, `EQR_ADDR_CONS, 32'h5);
        chk(nonempty_irq, 0);
        rdreg(`EQR_ADDR_GERR);
        chk(rd[0], 1);
        // Read abort raises the same error
        apb(1'b1, `EQR_ADDR_GERR_ACK, 32'h1);
        rd_abort <= 1'b1;
        @(posedge clk_sys);
        rd_abort <= 1'b0;
        rdreg(`EQR_ADDR_GERR);
        chk(rd[0], 1);
        give_verdict();
    end
endmodule

`default_nettype wire
